// ===== core/vtg_pkg.sv
// vertical timing package: register map, field layout, compare offsets
// assumes byte addressing on the register bus and 11-bit line fields
package vtg_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LINE_W = 11;
  localparam int NUM_REGS = 9;
  localparam int IDX_W = 4;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [15:0] FRAME_LINES_OFS = 16'h8340;
  localparam logic [15:0] BLANK_LINES_OFS = 16'h8344;
  localparam logic [15:0] CRT_VSYNC_LINES_OFS = 16'h8348;
  localparam logic [15:0] PANEL_VSYNC_LINES_OFS = 16'h834c;
  localparam logic [15:0] POINTER_HORIZ_OFS = 16'h8350;
  localparam logic [15:0] SCANLINE_OFS = 16'h8354;
  localparam logic [15:0] POINTER_VERT_OFS = 16'h8358;
  localparam logic [15:0] SPLIT_COMPARE_OFS = 16'h835c;
  localparam logic [15:0] TIMING_CONTROL_OFS = 16'h8360;

  // ****************************************
  // register indices (word steps from the first register)
  // ****************************************
  localparam logic [3:0] IDX_FRAME_LINES = 4'h0;
  localparam logic [3:0] IDX_BLANK_LINES = 4'h1;
  localparam logic [3:0] IDX_CRT_VSYNC = 4'h2;
  localparam logic [3:0] IDX_PANEL_VSYNC = 4'h3;
  localparam logic [3:0] IDX_POINTER_HORIZ = 4'h4;
  localparam logic [3:0] IDX_SCANLINE = 4'h5;
  localparam logic [3:0] IDX_POINTER_VERT = 4'h6;
  localparam logic [3:0] IDX_SPLIT_COMPARE = 4'h7;
  localparam logic [3:0] IDX_CONTROL = 4'h8;

  // ****************************************
  // field layout
  // ****************************************
  localparam int LO_LSB = 0;
  localparam int LO_MSB = 10;
  localparam int HI_LSB = 16;
  localparam int HI_MSB = 26;
  localparam int CTRL_INTERLACE_BIT = 0;
  localparam int CTRL_SPLIT_BIT = 1;
  localparam logic [31:0] PAIR_FIELD_MASK = 32'h07ff07ff;
  localparam logic [31:0] LOW_FIELD_MASK = 32'h000007ff;
  localparam logic [31:0] CONTROL_MASK = 32'h00000003;
  localparam logic [31:0] READ_ONLY_MASK = 32'h00000000;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

  // ****************************************
  // line compare offsets
  // ****************************************
  localparam logic [10:0] CRT_LINE_OFFSET = 11'h001;
  localparam logic [10:0] PANEL_LINE_OFFSET = 11'h002;
  localparam logic [10:0] LINE_ALL_ONES = 11'h7ff;
  localparam logic [10:0] LINE_ZERO = 11'h000;
  localparam logic [10:0] LINE_STEP = 11'h001;

  // writable bits of each register
  function automatic logic [31:0] regMask(input logic [3:0] idx);
    logic [31:0] m;
    m = READ_ONLY_MASK;
    case (idx)
      IDX_FRAME_LINES, IDX_BLANK_LINES, IDX_CRT_VSYNC,
      IDX_PANEL_VSYNC: m = PAIR_FIELD_MASK;
      IDX_POINTER_HORIZ, IDX_POINTER_VERT,
      IDX_SPLIT_COMPARE: m = LOW_FIELD_MASK;
      IDX_CONTROL: m = CONTROL_MASK;
      default: m = READ_ONLY_MASK;
    endcase
    return m;
  endfunction

endpackage

// ===== core/vtg_line_window.sv
// one begin/finish line window: flag set and cleared by line compares
// assumes step pulses in the same cycle the line counter shows its new value
`timescale 1ns/10ps
`default_nettype none

module vtg_line_window #(
  parameter logic [10:0] LINE_OFFSET = 11'h001
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // line input
  input wire logic step,
  input wire logic [10:0] line,
  // programmed lines
  input wire logic [10:0] beginLine,
  input wire logic [10:0] finishLine,
  // window flag
  output logic active
);

  logic activeQ;
  logic activeD;
  logic [10:0] beginMatch;
  logic [10:0] finishMatch;

  // ****************************************
  // compare
  // ****************************************
  always_comb begin
    beginMatch = 11'(beginLine + LINE_OFFSET);
    finishMatch = 11'(finishLine + LINE_OFFSET);
    activeD = activeQ;
    if (step && (line == beginMatch)) begin
      activeD = 1'b1;
    end else if (step && (line == finishMatch)) begin
      activeD = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      activeQ <= 1'b0;
    end else begin
      activeQ <= activeD;
    end
  end

  assign active = activeQ;

endmodule // vtg_line_window

`default_nettype wire

// ===== core/vtg_vertical_timing.sv
// vertical timing generator with cursor position and split line compare
// assumes crtHsync, panelHsync and halfLineStrobe come from horizontal
// timing on ref_clk; registers reached over avalon-mm with waitrequest
//
// Summary of operation
// - vertical blank starts on line equal to blank-begin field plus one
// - interlaced mode: blank window starts after active lines and ends at line zero
// - crt vertical sync ends on line equal to sync-finish plus one
// - crt vertical sync starts on line equal to sync-begin plus one
// - interlaced: line counter steps twice per scan line
// - panel vertical sync ends on line equal to panel finish plus two
// - panel vertical sync starts on line equal to panel begin plus two
// - panel vertical sync is retimed to panel horizontal sync
// - written cursor coordinates take effect only at next frame start
// - read-only register reports the current scan line
// - split mode: lower screen begins at split compare line
// - cursor group is four 32-bit registers from 8350h to 835ch
// - cursor x and y positions held in separate registers
// - line counter advances on the horizontal sync transition
// - programmed total-lines value sets the frame length
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module vtg_vertical_timing (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // horizontal timing inputs
  input wire logic crtHsync,
  input wire logic panelHsync,
  input wire logic halfLineStrobe,
  // display outputs
  output logic crtVblank,
  output logic crtVsync,
  output logic panelVsync,
  // cursor and line status
  output logic [10:0] cursorX,
  output logic [10:0] cursorY,
  output logic [10:0] currentLine,
  output logic frameStart,
  output logic lowerScreen
);

  // ****************************************
  // register file and bus state
  // ****************************************
  logic [31:0] regQ [vtg_pkg::NUM_REGS];
  logic [31:0] regD [vtg_pkg::NUM_REGS];
  logic ackQ;
  logic ackD;
  logic [31:0] rdataQ;
  logic [31:0] rdataD;
  logic request;
  logic hit;
  logic [15:0] wordOffset;
  logic [3:0] idx;
  logic [31:0] beMask;
  logic [31:0] readValue;

  // ****************************************
  // timing state
  // ****************************************
  logic [10:0] lineQ;
  logic [10:0] lineD;
  logic crtHsQ;
  logic crtHsD;
  logic panelHsQ;
  logic panelHsD;
  logic stepQ;
  logic stepD;
  logic frameQ;
  logic frameD;
  logic [10:0] cursorXQ;
  logic [10:0] cursorXD;
  logic [10:0] cursorYQ;
  logic [10:0] cursorYD;
  logic lowerQ;
  logic lowerD;
  logic panelVsQ;
  logic panelVsD;
  logic advance;
  logic wrapNow;
  logic interlaced;
  logic splitEnable;
  logic panelVsRaw;

  // ****************************************
  // register fields
  // ****************************************
  logic [10:0] totalLines;
  logic [10:0] activeLines;
  logic [10:0] blankBegin;
  logic [10:0] blankFinish;
  logic [10:0] blankBeginSel;
  logic [10:0] blankFinishSel;
  logic [10:0] crtSyncBegin;
  logic [10:0] crtSyncFinish;
  logic [10:0] panelSyncBegin;
  logic [10:0] panelSyncFinish;
  logic [10:0] splitLine;

  assign totalLines =
    regQ[vtg_pkg::IDX_FRAME_LINES][vtg_pkg::HI_MSB:vtg_pkg::HI_LSB];
  assign activeLines =
    regQ[vtg_pkg::IDX_FRAME_LINES][vtg_pkg::LO_MSB:vtg_pkg::LO_LSB];
  assign blankFinish =
    regQ[vtg_pkg::IDX_BLANK_LINES][vtg_pkg::HI_MSB:vtg_pkg::HI_LSB];
  assign blankBegin =
    regQ[vtg_pkg::IDX_BLANK_LINES][vtg_pkg::LO_MSB:vtg_pkg::LO_LSB];
  assign crtSyncFinish =
    regQ[vtg_pkg::IDX_CRT_VSYNC][vtg_pkg::HI_MSB:vtg_pkg::HI_LSB];
  assign crtSyncBegin =
    regQ[vtg_pkg::IDX_CRT_VSYNC][vtg_pkg::LO_MSB:vtg_pkg::LO_LSB];
  assign panelSyncFinish =
    regQ[vtg_pkg::IDX_PANEL_VSYNC][vtg_pkg::HI_MSB:vtg_pkg::HI_LSB];
  assign panelSyncBegin =
    regQ[vtg_pkg::IDX_PANEL_VSYNC][vtg_pkg::LO_MSB:vtg_pkg::LO_LSB];
  assign splitLine =
    regQ[vtg_pkg::IDX_SPLIT_COMPARE][vtg_pkg::LO_MSB:vtg_pkg::LO_LSB];
  assign interlaced =
    regQ[vtg_pkg::IDX_CONTROL][vtg_pkg::CTRL_INTERLACE_BIT];
  assign splitEnable =
    regQ[vtg_pkg::IDX_CONTROL][vtg_pkg::CTRL_SPLIT_BIT];

  // ****************************************
  // address decode and read mux
  // ****************************************
  always_comb begin
    request = avs_read | avs_write;
    wordOffset = 16'(avs_address - vtg_pkg::FRAME_LINES_OFS);
    hit = (avs_address >= vtg_pkg::FRAME_LINES_OFS) &&
          (avs_address <= vtg_pkg::TIMING_CONTROL_OFS) &&
          (avs_address[1:0] == 2'h0);
    idx = wordOffset[5:2];
    beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    readValue = vtg_pkg::UNMAPPED_READ;
    if (hit) begin
      if (idx == vtg_pkg::IDX_SCANLINE) begin
        readValue = {21'h0, lineQ};
      end else begin
        readValue = regQ[idx];
      end
    end
  end

  // ****************************************
  // bus handshake: one wait state per access
  // ****************************************
  always_comb begin
    ackD = request & ~ackQ;
    rdataD = rdataQ;
    if (avs_read && !ackQ) begin
      rdataD = readValue;
    end
    avs_waitrequest = request & ~ackQ;
  end

  // ****************************************
  // register writes
  // ****************************************
  always_comb begin
    for (int i = 0; i < vtg_pkg::NUM_REGS; i++) begin
      regD[i] = regQ[i];
    end
    if (avs_write && ackQ && hit) begin
      regD[idx] = (regQ[idx] & ~(beMask & vtg_pkg::regMask(idx))) |
                  (avs_writedata & beMask & vtg_pkg::regMask(idx));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ackQ <= 1'b0;
      rdataQ <= vtg_pkg::REG_RESET;
      for (int i = 0; i < vtg_pkg::NUM_REGS; i++) begin
        regQ[i] <= vtg_pkg::REG_RESET;
      end
    end else begin
      ackQ <= ackD;
      rdataQ <= rdataD;
      for (int i = 0; i < vtg_pkg::NUM_REGS; i++) begin
        regQ[i] <= regD[i];
      end
    end
  end

  // ****************************************
  // vertical line counter
  // ****************************************
  always_comb begin
    crtHsD = crtHsync;
    panelHsD = panelHsync;
    advance = (crtHsync & ~crtHsQ) |
              (interlaced & halfLineStrobe);
    wrapNow = advance && (lineQ == totalLines);
    lineD = lineQ;
    if (wrapNow) begin
      lineD = vtg_pkg::LINE_ZERO;
    end else if (advance) begin
      lineD = 11'(lineQ + vtg_pkg::LINE_STEP);
    end
    stepD = advance;
    frameD = wrapNow;
  end

  // ****************************************
  // cursor latch and split screen
  // ****************************************
  always_comb begin
    cursorXD = cursorXQ;
    cursorYD = cursorYQ;
    if (wrapNow) begin
      cursorXD = regQ[vtg_pkg::IDX_POINTER_HORIZ][10:0];
      cursorYD = regQ[vtg_pkg::IDX_POINTER_VERT][10:0];
    end
    lowerD = lowerQ;
    if (frameQ) begin
      lowerD = 1'b0;
    end
    if (stepQ && splitEnable && (lineQ == splitLine)) begin
      lowerD = 1'b1;
    end
  end

  // ****************************************
  // blank window selection
  // ****************************************
  always_comb begin
    blankBeginSel = blankBegin;
    blankFinishSel = blankFinish;
    if (interlaced) begin
      blankBeginSel = activeLines;
      blankFinishSel = vtg_pkg::LINE_ALL_ONES;
    end
  end

  // ****************************************
  // panel sync retiming
  // ****************************************
  always_comb begin
    panelVsD = panelVsQ;
    if (panelHsync && !panelHsQ) begin
      panelVsD = panelVsRaw;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lineQ <= vtg_pkg::LINE_ZERO;
      crtHsQ <= 1'b0;
      panelHsQ <= 1'b0;
      stepQ <= 1'b0;
      frameQ <= 1'b0;
      cursorXQ <= vtg_pkg::LINE_ZERO;
      cursorYQ <= vtg_pkg::LINE_ZERO;
      lowerQ <= 1'b0;
      panelVsQ <= 1'b0;
    end else begin
      lineQ <= lineD;
      crtHsQ <= crtHsD;
      panelHsQ <= panelHsD;
      stepQ <= stepD;
      frameQ <= frameD;
      cursorXQ <= cursorXD;
      cursorYQ <= cursorYD;
      lowerQ <= lowerD;
      panelVsQ <= panelVsD;
    end
  end

  // ****************************************
  // line windows
  // ****************************************
  vtg_line_window #(
    .LINE_OFFSET(vtg_pkg::CRT_LINE_OFFSET)
  ) blankWindow (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .step(stepQ),
    .line(lineQ),
    .beginLine(blankBeginSel),
    .finishLine(blankFinishSel),
    .active(crtVblank)
  );

  vtg_line_window #(
    .LINE_OFFSET(vtg_pkg::CRT_LINE_OFFSET)
  ) crtSyncWindow (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .step(stepQ),
    .line(lineQ),
    .beginLine(crtSyncBegin),
    .finishLine(crtSyncFinish),
    .active(crtVsync)
  );

  vtg_line_window #(
    .LINE_OFFSET(vtg_pkg::PANEL_LINE_OFFSET)
  ) panelSyncWindow (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .step(stepQ),
    .line(lineQ),
    .beginLine(panelSyncBegin),
    .finishLine(panelSyncFinish),
    .active(panelVsRaw)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata = rdataQ;
  assign panelVsync = panelVsQ;
  assign cursorX = cursorXQ;
  assign cursorY = cursorYQ;
  assign currentLine = lineQ;
  assign frameStart = frameQ;
  assign lowerScreen = lowerQ;

endmodule // vtg_vertical_timing

`default_nettype wire

// ===== bench/vtg_vertical_timing_sva.sv
// checker on the vertical timing ports
// assumes full byte enables on every register write
`timescale 1ns/10ps
`default_nettype none

module vtg_vertical_timing_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // timing
  input wire logic panelHsync,
  input wire logic crtVsync,
  input wire logic panelVsync,
  input wire logic [10:0] cursorX,
  input wire logic [10:0] currentLine,
  input wire logic frameStart,
  input wire logic lowerScreen
);
  // ****************************************
  // shadow of crt sync lines
  // ****************************************
  logic [10:0] begQ, begD, finQ, finD;
  always_comb begin
    begD = begQ;
    finD = finQ;
    if (avs_write && !avs_waitrequest &&
        avs_address == vtg_pkg::CRT_VSYNC_LINES_OFS) begin
      begD = avs_writedata[10:0];
      finD = avs_writedata[26:16];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      begQ <= 11'h000;
      finQ <= 11'h000;
    end else begin
      begQ <= begD;
      finQ <= finD;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence stepS;
    $changed(currentLine);
  endsequence
  sequence begS;
    stepS ##0 currentLine == begQ + 11'h001;
  endsequence
  sequence finS;
    stepS ##0 currentLine == finQ + 11'h001 &&
      currentLine != begQ + 11'h001;
  endsequence

  chk_wait_state: assert property (
    $rose(avs_read) || $rose(avs_write) |-> avs_waitrequest ##1
    !avs_waitrequest) else $error("wait state wrong");
  chk_vsync_begin: assert property (begS |=> crtVsync)
    else $error("crt vsync not set");
  chk_vsync_end: assert property (finS |=> !crtVsync)
    else $error("crt vsync not cleared");
  chk_line_step: assert property (stepS |->
    currentLine == $past(currentLine) + 11'h001 ||
    currentLine == 11'h000) else $error("line step wrong");
  chk_cursor_frame: assert property (
    $changed(cursorX) |-> currentLine == 11'h000)
    else $error("cursor moved mid frame");
  chk_frame_pulse: assert property (
    frameStart |-> currentLine == 11'h000 ##1 !frameStart)
    else $error("frame start pulse wrong");
  chk_panel_retime: assert property ($changed(panelVsync) |->
    $past(panelHsync) || $past(panelHsync, 2) || $past(panelHsync, 3))
    else $error("panel vsync not retimed");
  chk_lower_clear: assert property (
    frameStart |=> !lowerScreen) else $error("lower screen kept");
endmodule // vtg_vertical_timing_sva

bind vtg_vertical_timing vtg_vertical_timing_sva chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .panelHsync(panelHsync), .crtVsync(crtVsync), .panelVsync(panelVsync),
  .cursorX(cursorX), .currentLine(currentLine),
  .frameStart(frameStart), .lowerScreen(lowerScreen));
`default_nettype wire

// ===== bench/vtg_display_model.sv
// display model: measures sync pulse length in lines
// assumes hsync edges at least three cycles apart
`timescale 1ns/10ps
`default_nettype none

module vtg_display_model (
  // clock
  input wire logic ref_clk,
  // crt side
  input wire logic crtHsync,
  input wire logic crtVsync,
  // panel side
  input wire logic panelHsync,
  input wire logic panelVsync,
  // measured lines of last pulse
  output logic [7:0] crtLines,
  output logic [7:0] panelLines
);
  logic hq = 1'b0;
  logic pq = 1'b0;
  logic [7:0] hc = 8'h00;
  logic [7:0] pc = 8'h00;
  initial crtLines = 8'h00;
  initial panelLines = 8'h00;
  // pulse length counted at each rising hsync edge
  always @(posedge ref_clk) begin
    hq <= crtHsync;
    pq <= panelHsync;
    if (crtHsync && !hq) begin
      if (crtVsync) hc <= hc + 8'h01;
      else if (hc != 8'h00) begin
        crtLines <= hc;
        hc <= 8'h00;
      end
    end
    if (panelHsync && !pq) begin
      if (panelVsync) pc <= pc + 8'h01;
      else if (pc != 8'h00) begin
        panelLines <= pc;
        pc <= 8'h00;
      end
    end
  end
endmodule // vtg_display_model
`default_nettype wire

// ===== bench/vtg_vertical_timing_tb.sv
// testbench for the vertical timing block
// assumes one wait state bus and a 21 line frame (total-lines field 20)
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
  errCount++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module vtg_vertical_timing_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, rd, rd2;
  logic avs_waitrequest, crtVblank, crtVsync, panelVsync, frameStart;
  logic crtHsync = 1'b0;
  logic panelHsync = 1'b0;
  logic halfLineStrobe = 1'b0;
  logic lowerScreen;
  logic [10:0] cursorX, cursorY, currentLine;
  logic [10:0] cxReg = 11'h000;
  logic [10:0] cyReg = 11'h7ff;
  logic [10:0] cxExp = 11'h000;
  logic [10:0] cyExp = 11'h000;
  logic [7:0] crtLines, panelLines;
  logic il = 1'b0;
  int errCount = 0;
  int samplesChecked = 0;
  int ln = 0;

  always #5 ref_clk = ~ref_clk;

  vtg_vertical_timing DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .crtHsync(crtHsync),
    .panelHsync(panelHsync), .halfLineStrobe(halfLineStrobe),
    .crtVblank(crtVblank), .crtVsync(crtVsync), .panelVsync(panelVsync),
    .cursorX(cursorX), .cursorY(cursorY), .currentLine(currentLine),
    .frameStart(frameStart), .lowerScreen(lowerScreen));

  vtg_display_model disp (.ref_clk(ref_clk), .crtHsync(crtHsync),
    .crtVsync(crtVsync), .panelHsync(panelHsync),
    .panelVsync(panelVsync), .crtLines(crtLines),
    .panelLines(panelLines));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic endOfTest;
    $display("checks=%0d errors=%0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // request held until the rising edge that sees waitrequest low
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic adv;
    ln = (ln == 20) ? 0 : ln + 1;
    if (ln == 0) begin
      cxExp = cxReg;
      cyExp = cyReg;
    end
  endtask

  task automatic scan_line;
    @(posedge ref_clk);
    crtHsync <= 1'b1;
    repeat (2) @(posedge ref_clk);
    crtHsync <= 1'b0;
    adv();
    if (il) begin
      repeat (3) @(posedge ref_clk);
      halfLineStrobe <= 1'b1;
      @(posedge ref_clk);
      halfLineStrobe <= 1'b0;
      adv();
    end
    repeat (3) @(posedge ref_clk);
    panelHsync <= 1'b1;
    @(posedge ref_clk);
    panelHsync <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic regs_test;
    bus(0, vtg_pkg::CRT_VSYNC_LINES_OFS, 32'h0);
    `CHK(rd, 32'h00000000)
    bus(1, vtg_pkg::CRT_VSYNC_LINES_OFS, 32'hffffffff);
    bus(0, vtg_pkg::CRT_VSYNC_LINES_OFS, 32'h0);
    `CHK(rd, 32'h07ff07ff)
    bus(1, vtg_pkg::POINTER_VERT_OFS, 32'hffffffff);
    bus(0, vtg_pkg::POINTER_VERT_OFS, 32'h0);
    `CHK(rd, 32'h000007ff)
    bus(1, vtg_pkg::SCANLINE_OFS, 32'hffffffff);
    bus(0, vtg_pkg::SCANLINE_OFS, 32'h0);
    `CHK(rd, 32'h00000000)
    bus(0, 16'h8364, 32'h0);
    `CHK(rd, 32'h00000000)
  endtask

  task automatic run_lines(input int cnt);
    repeat (cnt) begin
      scan_line();
      `CHK(currentLine, ln[10:0])
      `CHK(crtVsync, ln inside {[5:6]})
      `CHK(crtVblank, il ? ln >= 16 : ln inside {[11:18]})
      `CHK(panelVsync, ln inside {[5:8]})
      `CHK(lowerScreen, ln >= 8)
      `CHK(cursorX, cxExp)
      `CHK(cursorY, cyExp)
      bus(0, vtg_pkg::SCANLINE_OFS, 32'h0);
      rd2 = rd;
      bus(0, vtg_pkg::SCANLINE_OFS, 32'h0);
      `CHK(rd, rd2)
      `CHK(rd, {21'h0, ln[10:0]})
    end
  endtask

  task automatic frames_test;
    bus(1, vtg_pkg::FRAME_LINES_OFS, 32'h0014000f);
    bus(1, vtg_pkg::BLANK_LINES_OFS, 32'h0012000a);
    bus(1, vtg_pkg::CRT_VSYNC_LINES_OFS, 32'h00060004);
    bus(1, vtg_pkg::PANEL_VSYNC_LINES_OFS, 32'h00070003);
    bus(1, vtg_pkg::SPLIT_COMPARE_OFS, 32'h00000008);
    bus(1, vtg_pkg::TIMING_CONTROL_OFS, 32'h00000002);
    run_lines(10);
    bus(1, vtg_pkg::POINTER_HORIZ_OFS, 32'h00000123);
    bus(1, vtg_pkg::POINTER_VERT_OFS, 32'h00000045);
    cxReg = 11'h123;
    cyReg = 11'h045;
    run_lines(32);
    `CHK(crtLines, 8'h02)
    `CHK(panelLines, 8'h04)
    bus(1, vtg_pkg::BLANK_LINES_OFS, 32'h00120010);
    bus(1, vtg_pkg::TIMING_CONTROL_OFS, 32'h00000003);
    il = 1'b1;
    run_lines(21);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    regs_test();
    frames_test();
    endOfTest();
  end

  initial begin
    #100000;
    errCount++;
    endOfTest();
  end
endmodule // vtg_vertical_timing_tb
`default_nettype wire
